// [rtl/cwp_cfg.svh]
// Purpose: constants of the code write protection block
// Assumes: included by the top module only
// Notes:   register indices times four give the byte addresses
`ifndef CWP_CFG_SVH
`define CWP_CFG_SVH
// register indices on the bus
`define CWP_IDX_UID0        16'h8000
`define CWP_IDX_UID3        16'h8003
`define CWP_IDX_PARTID      16'h8006
`define CWP_IDX_CFG2        16'h8007
`define CWP_IDX_NVW         16'h8008
`define CWP_IDX_STAT        16'h8009
// configuration word fields
`define CWP_CFG2_LOWV_BIT   4'd13
`define CWP_CFG2_DEBUG_BIT  4'd12
`define CWP_CFG2_GUARD_MSB  4'd1
`define CWP_CFG1_PLOCK_BIT  4'd7
`define CWP_CFG1_ELOCK_BIT  4'd8
`define CWP_CFG_RESET       14'h3fff
// self-write guard codes and bounds
`define CWP_GUARD_OFF       2'b11
`define CWP_GUARD_BOOT      2'b10
`define CWP_GUARD_HALF      2'b01
`define CWP_GUARD_ALL       2'b00
`define CWP_BOOT_TOP        16'h01ff
`define CWP_HALF_TOP_8K     16'h0fff
`define CWP_HALF_TOP_16K    16'h1fff
`define CWP_TOP_8K          16'h1fff
`define CWP_TOP_16K         16'h3fff
// identity word fields
`define CWP_PART_LSB        4'd5
`define CWP_SILID_LSB       4'd0
// control register fields
`define CWP_NVW_GO_BIT      5'd31
`define CWP_NVW_EE_BIT      5'd16
// bus answers
`define CWP_RESP_OKAY       2'b00
`define CWP_RESP_SLVERR     2'b10
`endif

// [rtl/cwp_pkg.sv]
// Purpose: types of the code write protection block
// Assumes: nothing
// Notes:   constants live in cwp_cfg.svh
package cwp_pkg;
  // request from the external programming interface
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        erase;
    logic        eeprom;
    logic [15:0] addr;
    logic [13:0] wdata;
  } cwp_ext_req_type;
  // answer to the external programming interface
  typedef struct packed {
    logic        valid;
    logic        allow;
    logic        zero_data;
    logic [13:0] rdata;
  } cwp_ext_ans_type;
  // self-write strobe towards the nonvolatile arrays
  typedef struct packed {
    logic        valid;
    logic        eeprom;
    logic [15:0] addr;
  } cwp_nvw_type;
  // bulk erase strobes
  typedef struct packed {
    logic prog;
    logic eeprom;
  } cwp_erase_type;
  // capture state
  typedef enum logic [1:0] {
    CWP_WAIT = 2'b01,
    CWP_HELD = 2'b10
  } cwp_cap_type;
endpackage

// [rtl/cwp_uid_mem.sv]
// Purpose: user identification words
// Assumes: one write and one read port on aclk
// Notes:   read data comes out of a register
`timescale 1ns/10ps
`default_nettype none
module cwp_uid_mem #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  // clock
  input  wire logic             aclk,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port
  input  wire logic [AW-1:0]    raddr,
  output var  logic [WIDTH-1:0] rdata_r
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata_r <= mem_r[raddr];
  end
endmodule // cwp_uid_mem
`default_nettype wire

// [rtl/cwp_guard.sv]
// Purpose: protection and identification logic of the nonvolatile memories
// Assumes: external tool requests come from same-clock programming logic
// Notes:   configuration words are sampled once after reset release
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cwp_cfg.svh"
module cwp_guard
  import cwp_pkg::*;
#(
  parameter logic       BIG_ARRAY = 1'b0,    // 16K-word variant when set
  parameter logic [8:0] PART_ID   = 9'h0a5,  // arbitrary value
  parameter logic [4:0] SIL_ID    = 5'h01    // arbitrary value
) (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address and data
  input  wire logic [17:0]               awaddr,
  input  wire logic                      awvalid,
  output var  logic                      awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output var  logic                      wready,
  // axi4-lite write response
  output var  logic [1:0]                bresp,
  output var  logic                      bvalid,
  input  wire logic                      bready,
  // axi4-lite read
  input  wire logic [17:0]               araddr,
  input  wire logic                      arvalid,
  output var  logic                      arready,
  output var  logic [31:0]               rdata,
  output var  logic [1:0]                rresp,
  output var  logic                      rvalid,
  input  wire logic                      rready,
  // nonvolatile configuration words
  input  wire logic [13:0]               cfg_word1,
  input  wire logic [13:0]               cfg_word2,
  input  wire logic                      lowv_entry,
  // external programming interface
  input  wire cwp_pkg::cwp_ext_req_type  ext_req,
  output var  cwp_pkg::cwp_ext_ans_type  ext_ans,
  output var  cwp_pkg::cwp_erase_type    ext_erase,
  // self-write strobe
  output var  cwp_pkg::cwp_nvw_type      nvw_out
);
  import cwp_pkg::*;

  localparam logic [15:0] HALF_TOP = BIG_ARRAY ? `CWP_HALF_TOP_16K : `CWP_HALF_TOP_8K;
  localparam logic [15:0] ARR_TOP  = BIG_ARRAY ? `CWP_TOP_16K : `CWP_TOP_8K;
  // captured configuration
  cwp_cap_type cap_state_r;
  logic        prog_lock_n_r;
  logic        ee_lock_n_r;
  logic [1:0]  guard_r;
  logic [13:0] cfg2_r;
  // bus state
  logic        aw_hold_r, w_hold_r, rd_stage_r;
  logic [15:0] aw_idx_r, ar_idx_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  // self-write control
  logic [15:0] nvw_addr_r;
  logic        nvw_ee_r, nvw_done_r, nvw_ok_r;
  cwp_nvw_type     nvw_r;
  cwp_ext_ans_type ans_r;
  cwp_erase_type   erase_r;
  logic [13:0]     uid_rdata;

  // capture of configuration, once after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_state_r   <= CWP_WAIT;
      prog_lock_n_r <= 1'b0;
      ee_lock_n_r   <= 1'b0;
      guard_r       <= `CWP_GUARD_ALL;
      cfg2_r        <= `CWP_CFG_RESET;
    end else begin
      case (cap_state_r)
        CWP_WAIT: begin
          prog_lock_n_r <= cfg_word1[`CWP_CFG1_PLOCK_BIT];
          ee_lock_n_r   <= cfg_word1[`CWP_CFG1_ELOCK_BIT];
          guard_r       <= cfg_word2[`CWP_CFG2_GUARD_MSB:0];
          cfg2_r        <= cfg_word2;
          cap_state_r   <= CWP_HELD;
        end
        CWP_HELD: cap_state_r <= CWP_HELD;
        default:  cap_state_r <= CWP_WAIT;
      endcase
    end
  end

  // self-write guard decode
  function automatic logic guard_blocks(input logic [1:0] g, input logic [15:0] a);
    logic [15:0] half;
    logic [15:0] top;
    half = BIG_ARRAY ? `CWP_HALF_TOP_16K : `CWP_HALF_TOP_8K;
    top  = BIG_ARRAY ? `CWP_TOP_16K : `CWP_TOP_8K;
    case (g)
      `CWP_GUARD_OFF:  guard_blocks = (a > top);
      `CWP_GUARD_BOOT: guard_blocks = (a <= `CWP_BOOT_TOP) || (a > top);
      `CWP_GUARD_HALF: guard_blocks = (a <= half) || (a > top);
      default:         guard_blocks = 1'b1;
    endcase
  endfunction

  wire held = (cap_state_r == CWP_HELD);

  // axi write path
  wire aw_take = awvalid & awready_r;
  wire w_take  = wvalid & wready_r;
  wire wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
  wire aw_hold_nxt = ~wr_fire & (aw_hold_r | aw_take);
  wire w_hold_nxt  = ~wr_fire & (w_hold_r | w_take);
  wire wr_full  = (wstrb_r == 4'hf);
  wire wr_uid   = (aw_idx_r >= `CWP_IDX_UID0) && (aw_idx_r <= `CWP_IDX_UID3);
  wire wr_nvw   = (aw_idx_r == `CWP_IDX_NVW);
  wire wr_ro    = (aw_idx_r == `CWP_IDX_PARTID) || (aw_idx_r == `CWP_IDX_CFG2) ||
                  (aw_idx_r == `CWP_IDX_STAT);
  wire wr_map   = wr_uid | wr_nvw | wr_ro;
  wire uid_we   = wr_fire & wr_uid & (wstrb_r[1:0] == 2'b11);
  wire nvw_go   = wr_fire & wr_nvw & wr_full & wdata_r[`CWP_NVW_GO_BIT];
  wire nvw_ee   = wdata_r[`CWP_NVW_EE_BIT];
  wire [15:0] nvw_a = wdata_r[15:0];
  // cpu writes: eeprom always, program only by guard
  wire nvw_allow = held & (nvw_ee | ~guard_blocks(guard_r, nvw_a));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `CWP_RESP_OKAY;
      aw_idx_r  <= 16'h0000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt;
      wready_r  <= ~w_hold_nxt;
      if (aw_take) begin
        aw_idx_r <= awaddr[17:2];
      end
      if (w_take) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_map ? `CWP_RESP_OKAY : `CWP_RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // self-write control register and strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nvw_addr_r <= 16'h0000;
      nvw_ee_r   <= 1'b0;
      nvw_done_r <= 1'b0;
      nvw_ok_r   <= 1'b0;
      nvw_r      <= '0;
    end else begin
      nvw_r.valid <= nvw_go & nvw_allow;
      if (nvw_go) begin
        nvw_addr_r   <= nvw_a;
        nvw_ee_r     <= nvw_ee;
        nvw_done_r   <= 1'b1;
        nvw_ok_r     <= nvw_allow;
        nvw_r.eeprom <= nvw_ee;
        nvw_r.addr   <= nvw_a;
      end
    end
  end

  // axi read path, two cycles from address to data
  wire ar_take = arvalid & arready_r;
  wire [1:0] uid_raddr = ar_take ? araddr[3:2] : ar_idx_r[1:0];
  wire [15:0] ri = ar_idx_r;
  wire rd_uid = (ri >= `CWP_IDX_UID0) && (ri <= `CWP_IDX_UID3);
  wire [13:0] part_word = {PART_ID, SIL_ID};
  wire [31:0] stat_word = {26'h0000000, lowv_entry, held, guard_r, ee_lock_n_r, prog_lock_n_r};
  wire [31:0] nvw_word  = {14'h0000, nvw_ok_r, nvw_ee_r, nvw_addr_r};
  wire [31:0] rd_mux =
      rd_uid                        ? {18'h00000, uid_rdata} :
      (ri == `CWP_IDX_PARTID)       ? {18'h00000, part_word} :
      (ri == `CWP_IDX_CFG2)         ? {18'h00000, cfg2_r} :
      (ri == `CWP_IDX_NVW)          ? {nvw_word[31:17], nvw_done_r, nvw_word[15:0]} :
      (ri == `CWP_IDX_STAT)         ? stat_word : 32'h0000_0000;
  wire rd_map = rd_uid || (ri == `CWP_IDX_PARTID) || (ri == `CWP_IDX_CFG2) ||
                (ri == `CWP_IDX_NVW) || (ri == `CWP_IDX_STAT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r  <= 1'b0;
      rd_stage_r <= 1'b0;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= `CWP_RESP_OKAY;
      ar_idx_r   <= 16'h0000;
    end else begin
      rd_stage_r <= ar_take;
      arready_r  <= ~ar_take & ~rd_stage_r & (~rvalid_r | rready) & ~arready_r;
      if (ar_take) begin
        ar_idx_r <= araddr[17:2];
      end
      if (rd_stage_r) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= rd_map ? `CWP_RESP_OKAY : `CWP_RESP_SLVERR;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // user identification store
  cwp_uid_mem #(
    .WIDTH (14),
    .DEPTH (4),
    .AW    (2)
  ) u_uid (
    .aclk    (aclk),
    .we      (uid_we),
    .waddr   (aw_idx_r[1:0]),
    .wdata   (wdata_r[13:0]),
    .raddr   (uid_raddr),
    .rdata_r (uid_rdata)
  );

  // external tool gating
  wire x_cfg    = ext_req.addr[15] & ~ext_req.eeprom;
  wire x_prog   = ~ext_req.eeprom & ~x_cfg;
  wire x_ee     = ext_req.eeprom;
  wire x_id     = x_cfg & (ext_req.addr == `CWP_IDX_PARTID);
  wire x_cfg2   = x_cfg & (ext_req.addr == `CWP_IDX_CFG2);
  wire x_lowv_clr = ext_req.write & x_cfg2 & ~ext_req.wdata[`CWP_CFG2_LOWV_BIT] & lowv_entry;
  wire x_allow =
      ~held                      ? 1'b0 :
      x_ee                       ? ee_lock_n_r :
      x_prog                     ? (prog_lock_n_r | ~ext_req.write) :
      x_id                       ? ~ext_req.write :
      x_lowv_clr                 ? 1'b0 : 1'b1;
  wire x_zero = x_prog & ~ext_req.write & ~prog_lock_n_r;
  wire [13:0] x_rdata = x_id ? part_word : x_cfg2 ? cfg2_r : 14'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ans_r   <= '0;
      erase_r <= '0;
    end else begin
      ans_r.valid <= ext_req.valid & ~ext_req.erase;
      if (ext_req.valid & ~ext_req.erase) begin
        ans_r.allow     <= x_allow;
        ans_r.zero_data <= x_zero;
        ans_r.rdata     <= ext_req.write ? 14'h0000 : x_rdata;
      end
      // bulk erase clears its array, a program erase also a locked eeprom; the locks are kept
      erase_r.prog   <= ext_req.valid & ext_req.erase & ~ext_req.eeprom;
      erase_r.eeprom <= ext_req.valid & ext_req.erase & (ext_req.eeprom | ~ee_lock_n_r);
    end
  end

  // output drive
  assign awready   = awready_r;
  assign wready    = wready_r;
  assign bvalid    = bvalid_r;
  assign bresp     = bresp_r;
  assign arready   = arready_r;
  assign rvalid    = rvalid_r;
  assign rdata     = rdata_r;
  assign rresp     = rresp_r;
  assign ext_ans   = ans_r;
  assign ext_erase = erase_r;
  assign nvw_out   = nvw_r;

  // checks
  a_guard_all_deny: assert property (@(posedge aclk) disable iff (!aresetn)
    nvw_go && !nvw_ee && guard_r == `CWP_GUARD_ALL |=> !nvw_out.valid)
    else $error("self-write passed with full guard");
  a_guard_off_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    nvw_go && held && guard_r == `CWP_GUARD_OFF && nvw_a <= ARR_TOP |=> nvw_out.valid)
    else $error("self-write refused with guard off");
  a_guard_boot: assert property (@(posedge aclk) disable iff (!aresetn)
    nvw_go && held && !nvw_ee && guard_r == `CWP_GUARD_BOOT |=>
      nvw_out.valid == ($past(nvw_a) > `CWP_BOOT_TOP && $past(nvw_a) <= ARR_TOP))
    else $error("boot guard bound wrong");
  a_guard_half: assert property (@(posedge aclk) disable iff (!aresetn)
    nvw_go && held && !nvw_ee && guard_r == `CWP_GUARD_HALF |=>
      nvw_out.valid == ($past(nvw_a) > HALF_TOP && $past(nvw_a) <= ARR_TOP))
    else $error("half guard bound wrong");
  a_cpu_ee_free: assert property (@(posedge aclk) disable iff (!aresetn)
    nvw_go && held && nvw_ee |=> nvw_out.valid)
    else $error("cpu eeprom write refused");
  a_prog_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_req.valid && !ext_req.erase && held && !prog_lock_n_r && x_prog |=>
      ext_ans.valid && (ext_ans.allow == !$past(ext_req.write)) &&
      (ext_ans.zero_data == !$past(ext_req.write)))
    else $error("program lock not applied");
  a_ee_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_req.valid && !ext_req.erase && held && !ee_lock_n_r && ext_req.eeprom |=>
      ext_ans.valid && !ext_ans.allow)
    else $error("eeprom lock not applied");
  a_lowv_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_req.valid && !ext_req.erase && x_lowv_clr |=> !ext_ans.allow)
    else $error("low-voltage bit cleared in low-voltage mode");
  a_id_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_req.valid && !ext_req.erase && !ext_req.write && x_id && held |=>
      ext_ans.allow && ext_ans.rdata[13:5] == PART_ID && ext_ans.rdata[4:0] == SIL_ID)
    else $error("identity word read wrong");
  a_cfg_held: assert property (@(posedge aclk) disable iff (!aresetn)
    held |=> $stable(guard_r) && $stable(prog_lock_n_r) && $stable(ee_lock_n_r))
    else $error("captured configuration changed");
  a_erase_prog: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_req.valid && ext_req.erase && !ext_req.eeprom |=> ext_erase.prog)
    else $error("program erase missing");
  c_self_write: cover property (@(posedge aclk) disable iff (!aresetn) nvw_out.valid);
  c_ext_zero:   cover property (@(posedge aclk) disable iff (!aresetn) ext_ans.zero_data);
  c_uid_write:  cover property (@(posedge aclk) disable iff (!aresetn) uid_we);
  c_ee_erase:   cover property (@(posedge aclk) disable iff (!aresetn) ext_erase.eeprom);
endmodule // cwp_guard
`default_nettype wire

// [testbench/cwp_tool_model.sv]
// Purpose: behavioural programming tool on the external port
// Assumes: same clock as the guard block
// Notes:   address and data lines toggle while no request is valid
`timescale 1ns/10ps
`default_nettype none
module cwp_tool_model (
  // clock
  input  wire logic                     aclk,
  // command from the bench
  input  wire logic                     go,
  input  wire cwp_pkg::cwp_ext_req_type cmd,
  // tool port
  output var  cwp_pkg::cwp_ext_req_type ext_req,
  input  wire cwp_pkg::cwp_ext_ans_type ext_ans,
  input  wire cwp_pkg::cwp_erase_type   ext_erase,
  // captured answers
  output var  cwp_pkg::cwp_ext_ans_type ans_seen,
  output var  cwp_pkg::cwp_erase_type   erase_seen
);
  import cwp_pkg::*;
  // one request per go, idle lines never repeat the last value
  always @(posedge aclk) begin
    if (go) begin
      ext_req <= '{1'b1, cmd.write, cmd.erase, cmd.eeprom, cmd.addr,
                   cmd.wdata | ((cmd.write && cmd.addr == 16'h8007) ? 14'h1000 : 14'h0000)};
    end else begin
      ext_req.valid <= 1'b0;
      ext_req.addr <= ~ext_req.addr;
      ext_req.wdata <= ~ext_req.wdata;
    end
    ans_seen <= ext_ans.valid ? ext_ans : (go ? '0 : ans_seen);
    erase_seen <= go ? '0 : (erase_seen | ext_erase);
  end
endmodule  // cwp_tool_model
`default_nettype wire

// [testbench/code_write_protection_tb.sv]
// Purpose: self-checking bench of the protection block
// Assumes: 8K array, bready and rready held high
// Notes:   each configuration is captured by its own reset
`timescale 1ns/10ps
`default_nettype none
module code_write_protection_tb;
  import cwp_pkg::*;
  localparam logic [8:0] PART_TB = 9'h15a;  // arbitrary value
  localparam logic [4:0] SIL_TB  = 5'h0b;   // arbitrary value
  logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lowv_entry, go;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [17:0]     awaddr, araddr;
  logic [31:0]     wdata, rdata, lfsr_r;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp;
  logic [13:0]     cfg_word1, cfg_word2;
  cwp_ext_req_type ext_req, cmd;
  cwp_ext_ans_type ext_ans, ans_seen;
  cwp_erase_type   ext_erase, erase_seen;
  cwp_nvw_type     nvw_out;
  int              errors, comparisons;
  int              nvw_cnt = 0;
  cwp_nvw_type     nvw_last;
  cwp_guard #(.BIG_ARRAY(1'b0), .PART_ID(PART_TB), .SIL_ID(SIL_TB)) cwp_guard_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cfg_word1(cfg_word1), .cfg_word2(cfg_word2), .lowv_entry(lowv_entry),
    .ext_req(ext_req), .ext_ans(ext_ans), .ext_erase(ext_erase), .nvw_out(nvw_out));
  cwp_tool_model cwp_tool_model_i (
    .aclk(aclk), .go(go), .cmd(cmd), .ext_req(ext_req), .ext_ans(ext_ans),
    .ext_erase(ext_erase), .ans_seen(ans_seen), .erase_seen(erase_seen));
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (nvw_out.valid === 1'b1) begin
      nvw_cnt  <= nvw_cnt + 1;
      nvw_last <= nvw_out;
    end
  end
  function automatic void rnd(output logic [31:0] v);
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    v = lfsr_r;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  // expected self-write outcome on the 8K array
  function automatic logic sw_ok(input logic [1:0] g, input logic [15:0] a);
    case (g)
      2'b11:   return a <= 16'h1fff;
      2'b10:   return a > 16'h01ff && a <= 16'h1fff;
      2'b01:   return a > 16'h0fff && a <= 16'h1fff;
      default: return 1'b0;
    endcase
  endfunction
  task automatic axi_write(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int t;
    t = 0;
    r = 2'b11;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (t < 50) begin
      @(posedge aclk);
      t++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && !awvalid && !wvalid) begin
        r = bresp;
        break;
      end
    end
    check(t < 50, 1, "write wait");
  endtask
  task automatic axi_read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    while (t < 50) begin
      @(posedge aclk);
      t++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && !arvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    check(t < 50, 1, "read wait");
  endtask
  task automatic tool(input logic w, input logic er, input logic ee, input logic [15:0] a,
                      input logic [13:0] d);
    cmd <= '{1'b1, w, er, ee, a, d};
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict;
  end
  initial begin
    logic [15:0] sw_addr [7];
    logic [13:0] uid [4];
    logic [31:0] v, d;
    logic [15:0] a;
    logic [1:0]  g, r;
    logic        p, e, l, ee, x;
    int          n0;
    sw_addr = '{16'h0000, 16'h01ff, 16'h0200, 16'h0fff, 16'h1000, 16'h1fff, 16'h2000};
    aclk = 0; aresetn = 0; awaddr = 0; awvalid = 0; wdata = 0; wstrb = 0; wvalid = 0;
    bready = 1; araddr = 0; arvalid = 0; rready = 1; cfg_word1 = 14'h3fff;
    cfg_word2 = 14'h3fff; lowv_entry = 0; go = 0; cmd = '0; errors = 0; comparisons = 0;
    lfsr_r = 32'hec961e87;
    for (int i = 0; i < 4; i++) begin
      g = i[1:0];
      p = i[0];
      e = i[1];
      l = i[0] ^ i[1];
      @(posedge aclk);
      aresetn <= 1'b0;
      cfg_word1 <= {5'h1f, e, p, 7'h7f};
      cfg_word2 <= {12'hfff, g};
      lowv_entry <= l;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rnd(v);
      cfg_word1 <= v[13:0];
      cfg_word2 <= v[27:14];
      axi_read(18'h20024, d, r);
      check(d[5:0], {l, 1'b1, g, e, p}, "captured config");
      for (int k = 0; k < 8; k++) begin
        rnd(v);
        ee = (k == 7);
        a = ee ? v[15:0] : sw_addr[k];
        x = ee ? 1'b1 : sw_ok(g, a);
        n0 = nvw_cnt;
        axi_write(18'h20020, {1'b1, 14'h0, ee, a}, 4'hf, r);
        repeat (2) @(posedge aclk);
        check(nvw_cnt - n0, x, "self-write strobe");
        if (x) check(nvw_last, {1'b1, ee, a}, "self-write target");
        axi_read(18'h20020, d, r);
        check(d[17], x, "self-write ok");
      end
      rnd(v);
      tool(0, 0, 0, {3'h0, v[12:0]}, 14'h0);
      check({ans_seen.valid, ans_seen.allow, ans_seen.zero_data}, {2'b11, ~p}, "prog rd");
      if (!p) check(ans_seen.rdata, 0, "locked read data");
      tool(1, 0, 0, {3'h0, v[12:0]}, v[27:14]);
      check({ans_seen.valid, ans_seen.allow}, {1'b1, p}, "prog wr");
      tool(0, 0, 1, {8'h0, v[7:0]}, 14'h0);
      check({ans_seen.valid, ans_seen.allow}, {1'b1, e}, "eeprom rd");
      tool(1, 0, 1, {8'h0, v[15:8]}, v[13:0]);
      check({ans_seen.valid, ans_seen.allow}, {1'b1, e}, "eeprom wr");
      tool(0, 0, 0, 16'h8006, 14'h0);
      check({ans_seen.allow, ans_seen.rdata}, {1'b1, PART_TB, SIL_TB}, "id rd");
      tool(1, 0, 0, 16'h8006, v[13:0]);
      check({ans_seen.valid, ans_seen.allow}, 2'b10, "id wr");
      tool(0, 0, 0, 16'h8007, 14'h0);
      check({ans_seen.valid, ans_seen.allow, ans_seen.rdata}, {2'b11, 12'hfff, g}, "word two rd");
      tool(1, 0, 0, 16'h8007, {1'b0, v[12:0]});
      check({ans_seen.valid, ans_seen.allow}, {1'b1, ~l}, "low-voltage bit");
      tool(0, 1, 0, 16'h0, 14'h0);
      check(erase_seen, {1'b1, ~e}, "bulk erase");
      tool(0, 1, 1, 16'h0, 14'h0);
      check(erase_seen.eeprom, 1, "eeprom erase");
      for (int u = 0; u < 4; u++) begin
        rnd(v);
        uid[u] = v[13:0];
        axi_write(18'h20000 + 18'(u * 4), {18'h0, uid[u]}, 4'hf, r);
        check(r, 2'b00, "uid write resp");
      end
      for (int u = 0; u < 4; u++) begin
        axi_read(18'h20000 + 18'(u * 4), d, r);
        check({r, d}, {2'b00, 18'h0, uid[u]}, "uid read");
      end
      axi_write(18'h20018, 32'h3fff, 4'hf, r);
      check(r, 2'b00, "id write resp");
      axi_read(18'h20018, d, r);
      check({r, d}, {2'b00, 18'h0, PART_TB, SIL_TB}, "id read");
      axi_read(18'h20040, d, r);
      check({r, d}, {2'b10, 32'h0}, "unmapped read");
      axi_write(18'h20040, v, 4'hf, r);
      check(r, 2'b10, "unmapped write");
      $display("test config %0d done", i);
    end
    print_verdict;
  end
endmodule  // code_write_protection_tb
`default_nettype wire
